/* File: core/rsq_pkg.sv */
// rsq_pkg: constants for the reset sequencer and its register bank
// assumes: 32-bit axi4-lite data, byte addresses, one 8-bit register per word
//--------------------------------------------------------------------
// Overview of operation
// - reset accepted after sixteen oscillator cycles low
// - stay in reset while input low
// - start address from vector bytes fffd/fffc
// - port data and direction cleared to zero
// - both source selects load 0x33
// - serial status resets to 0x80
// - async control resets to 0xe0
// - aux timer bytes preset to 0xff
// - interrupt request and enable cleared
// - both dac values cleared
// - baud, buffers, pwm, adc left unset
// - middle-speed clock: oscillator divided by eight
// - undefined registers need software initialisation
//--------------------------------------------------------------------
package rsq_pkg;

	localparam int          RSQ_MIN_LOW_CYC   = 16;
	localparam int          RSQ_CNT_W         = 5;
	localparam int          RSQ_MID_DIV       = 8;
	localparam int          RSQ_DIV_W         = 3;
	localparam int          RSQ_NREG          = 64;
	localparam int          RSQ_IDX_W         = 6;
	localparam logic [15:0] RSQ_VEC_LO_ADDR   = 16'hfffc;
	localparam logic [15:0] RSQ_VEC_HI_ADDR   = 16'hfffd;

	// register indices; byte address is four times the index
	localparam logic [5:0] RSQ_PORT_FIRST    = 6'h00;
	localparam logic [5:0] RSQ_PORT_LAST     = 6'h0d;
	localparam logic [5:0] RSQ_SRC_SEL_A     = 6'h0e;
	localparam logic [5:0] RSQ_SRC_SEL_B     = 6'h0f;
	localparam logic [5:0] RSQ_SER_A_BUF     = 6'h18;
	localparam logic [5:0] RSQ_SER_A_STATE   = 6'h19;
	localparam logic [5:0] RSQ_ASYNC_A_CTRL  = 6'h1b;
	localparam logic [5:0] RSQ_BAUD_A        = 6'h1c;
	localparam logic [5:0] RSQ_AUX_TMR_LO    = 6'h28;
	localparam logic [5:0] RSQ_AUX_TMR_HI    = 6'h29;
	localparam logic [5:0] RSQ_PWM_PRE       = 6'h2c;
	localparam logic [5:0] RSQ_PWM_VAL       = 6'h2d;
	localparam logic [5:0] RSQ_BAUD_C        = 6'h2f;
	localparam logic [5:0] RSQ_SER_C_BUF     = 6'h30;
	localparam logic [5:0] RSQ_ADC_LOW       = 6'h35;
	localparam logic [5:0] RSQ_DAC_A         = 6'h36;
	localparam logic [5:0] RSQ_DAC_B         = 6'h37;
	localparam logic [5:0] RSQ_IRQ_REQ_A     = 6'h3c;
	localparam logic [5:0] RSQ_IRQ_REQ_B     = 6'h3d;
	localparam logic [5:0] RSQ_IRQ_EN_A      = 6'h3e;
	localparam logic [5:0] RSQ_IRQ_EN_B      = 6'h3f;

	// status/control words outside the 8-bit bank
	localparam logic [11:0] RSQ_STATUS_ADDR  = 12'h100;
	localparam logic [11:0] RSQ_VECTOR_ADDR  = 12'h104;
	localparam logic [11:0] RSQ_VECLD_ADDR   = 12'h108;
	localparam int          RSQ_BANK_TOP     = 256;

	localparam logic [7:0] RSQ_RST_ZERO      = 8'h00;
	localparam logic [7:0] RSQ_RST_SRC_SEL   = 8'h33;
	localparam logic [7:0] RSQ_RST_SER_STATE = 8'h80;
	localparam logic [7:0] RSQ_RST_ASYNC     = 8'he0;
	localparam logic [7:0] RSQ_RST_AUX_TMR   = 8'hff;

	localparam logic [1:0] RSQ_RESP_OKAY     = 2'b00;
	localparam logic [1:0] RSQ_RESP_SLVERR   = 2'b10;

	typedef enum logic [1:0] {
		RSQ_ST_RESET,
		RSQ_ST_VEC_HI,
		RSQ_ST_VEC_LO,
		RSQ_ST_RUN
	} rsq_state_t;

endpackage : rsq_pkg

/* File: core/rsq_in_sync.sv */
// rsq_in_sync: three-stage synchroniser with agreement filter
// assumes: input asynchronous to clk_i; output changes when stages 2 and 3 agree
`timescale 1ns/100ps
module rsq_in_sync (
	input  wire logic clk_i,    // sampling clock
	input  wire logic rst_n_i,  // async reset, active low
	input  wire logic async_i,  // raw pin level
	output logic      level_o   // filtered level
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1      <= 1'b0;
			s2      <= 1'b0;
			s3      <= 1'b0;
			level_o <= 1'b0;
		end else begin
			s1 <= async_i;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				level_o <= s3;
		end
	end
endmodule : rsq_in_sync

/* File: core/rsq_reg_mem.sv */
// rsq_reg_mem: 64 x 8 register bank with registered read data
// assumes: one write port, one read port, same clock; no reset of contents
`timescale 1ns/100ps
module rsq_reg_mem (
	input  wire logic       clk_i,    // clock
	input  wire logic       we_i,     // write strobe
	input  wire logic [5:0] waddr_i,  // write index
	input  wire logic [7:0] wdata_i,  // write data
	input  wire logic [5:0] raddr_i,  // read index
	output logic      [7:0] rdata_o   // registered read data
);
	logic [7:0] mem [0:63];

	always_ff @(posedge clk_i) begin
		if (we_i)
			mem[waddr_i] <= wdata_i;
		rdata_o <= mem[raddr_i];
	end
endmodule : rsq_reg_mem

/* File: core/rsq_top.sv */
// rsq_top: reset sequencer with power-on register load and vector fetch
// assumes: SYS_CLK_I is the main oscillator; axi4-lite master on the same clock
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
module rsq_top (
	input  wire logic        SYS_CLK_I,        // main oscillator clock
	input  wire logic        RESETN_I,         // async reset, active low
	input  wire logic        RESET_PIN_N_I,    // external reset pin, active low
	output logic             CORE_RESET_N_O,   // internal reset, active low
	output logic             CLK_PHI_EN_O,     // one-cycle pulse every eighth clock
	output logic             MID_SPEED_O,      // middle-speed mode selected
	output logic [15:0]      START_ADDR_O,     // fetched start address
	output logic             START_VALID_O,    // start address valid
	input  wire logic        AWVALID,          // write address valid
	output logic             AWREADY,          // write address ready
	input  wire logic [11:0] AWADDR,           // write address
	input  wire logic        WVALID,           // write data valid
	output logic             WREADY,           // write data ready
	input  wire logic [31:0] WDATA,            // write data
	input  wire logic [3:0]  WSTRB,            // write strobes
	output logic             BVALID,           // write response valid
	input  wire logic        BREADY,           // write response ready
	output logic [1:0]       BRESP,            // write response
	input  wire logic        ARVALID,          // read address valid
	output logic             ARREADY,          // read address ready
	input  wire logic [11:0] ARADDR,           // read address
	output logic             RVALID,           // read data valid
	input  wire logic        RREADY,           // read data ready
	output logic [31:0]      RDATA,            // read data
	output logic [1:0]       RRESP             // read response
);
	import rsq_pkg::*;

	//------------------------------------------------------------
	// pin synchroniser and low-time counter
	//------------------------------------------------------------
	logic                 pin_lvl;
	logic [RSQ_CNT_W-1:0] low_cnt;
	logic                 core_rst;
	rsq_state_t           state;

	rsq_in_sync u_sync (
		.clk_i   (SYS_CLK_I),
		.rst_n_i (RESETN_I),
		.async_i (RESET_PIN_N_I),
		.level_o (pin_lvl)
	);

	wire low_done = (low_cnt == RSQ_CNT_W'(RSQ_MIN_LOW_CYC));

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I)
			low_cnt <= '0;
		else if (pin_lvl)
			low_cnt <= '0;
		else if (!low_done)
			low_cnt <= low_cnt + 1'b1;
	end

	// hold reset while pin low, release on high
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I)
			core_rst <= 1'b1;
		else if (low_done)
			core_rst <= 1'b1;
		else if (pin_lvl)
			core_rst <= 1'b0;
	end

	//------------------------------------------------------------
	// reset load walk over the register bank
	//------------------------------------------------------------
	logic [RSQ_IDX_W-1:0] init_idx;
	logic                 init_busy;
	logic [7:0]           init_val;
	logic                 init_keep;

	wire is_port = (init_idx <= RSQ_PORT_LAST);
	wire is_undef = (init_idx == RSQ_SER_A_BUF) || (init_idx == RSQ_BAUD_A) ||
	                (init_idx == RSQ_PWM_PRE) || (init_idx == RSQ_PWM_VAL) ||
	                (init_idx == RSQ_BAUD_C) || (init_idx == RSQ_SER_C_BUF) ||
	                (init_idx == RSQ_ADC_LOW);

	always_comb begin
		init_keep = 1'b0;
		init_val  = RSQ_RST_ZERO;
		if (is_port)
			init_val = RSQ_RST_ZERO;
		else if ((init_idx == RSQ_SRC_SEL_A) || (init_idx == RSQ_SRC_SEL_B))
			init_val = RSQ_RST_SRC_SEL;
		else if (init_idx == RSQ_SER_A_STATE)
			init_val = RSQ_RST_SER_STATE;
		else if (init_idx == RSQ_ASYNC_A_CTRL)
			init_val = RSQ_RST_ASYNC;
		else if ((init_idx == RSQ_AUX_TMR_LO) || (init_idx == RSQ_AUX_TMR_HI))
			init_val = RSQ_RST_AUX_TMR;
		else if ((init_idx >= RSQ_IRQ_REQ_A) && (init_idx <= RSQ_IRQ_EN_B))
			init_val = RSQ_RST_ZERO;
		else if ((init_idx == RSQ_DAC_A) || (init_idx == RSQ_DAC_B))
			init_val = RSQ_RST_ZERO;
		else
			init_keep = 1'b1;
		if (is_undef)
			init_keep = 1'b1;
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			init_idx  <= '0;
			init_busy <= 1'b1;
		end else if (core_rst) begin
			init_idx  <= init_busy ? init_idx + 1'b1 : '0;
			init_busy <= init_busy ? (init_idx != RSQ_IDX_W'(RSQ_NREG - 1)) : 1'b1;
			if (!init_busy)
				init_idx <= '0;
		end else if (init_busy) begin
			init_idx  <= init_idx + 1'b1;
			init_busy <= (init_idx != RSQ_IDX_W'(RSQ_NREG - 1));
		end
	end

	//------------------------------------------------------------
	// vector bytes and start sequence
	//------------------------------------------------------------
	logic [7:0]  vec_hi;
	logic [7:0]  vec_lo;
	logic [15:0] start_addr;

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			state      <= RSQ_ST_RESET;
			start_addr <= '0;
		end else if (core_rst) begin
			state <= RSQ_ST_RESET;
		end else begin
			unique case (state)
				RSQ_ST_RESET:  if (!init_busy) state <= RSQ_ST_VEC_HI;
				RSQ_ST_VEC_HI: begin
					start_addr[15:8] <= vec_hi;
					state            <= RSQ_ST_VEC_LO;
				end
				RSQ_ST_VEC_LO: begin
					start_addr[7:0] <= vec_lo;
					state           <= RSQ_ST_RUN;
				end
				RSQ_ST_RUN:    state <= RSQ_ST_RUN;
			endcase
		end
	end

	assign START_ADDR_O   = start_addr;
	assign START_VALID_O  = (state == RSQ_ST_RUN);
	assign CORE_RESET_N_O = (state == RSQ_ST_RUN);

	//------------------------------------------------------------
	// middle-speed clock divider
	//------------------------------------------------------------
	logic [RSQ_DIV_W-1:0] div_cnt;
	logic                 phi_en;

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			div_cnt <= '0;
			phi_en  <= 1'b0;
		end else if (state != RSQ_ST_RUN) begin
			div_cnt <= '0;
			phi_en  <= 1'b0;
		end else begin
			div_cnt <= div_cnt + 1'b1;
			phi_en  <= (div_cnt == RSQ_DIV_W'(RSQ_MID_DIV - 1));
		end
	end

	assign CLK_PHI_EN_O = phi_en;
	assign MID_SPEED_O  = (state == RSQ_ST_RUN);

	//------------------------------------------------------------
	// axi4-lite slave
	//------------------------------------------------------------
	logic        aw_held;
	logic        w_held;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        ar_pend;
	logic        rd_wait;
	logic [11:0] ar_addr;
	logic [7:0]  mem_rdata;

	// a channel stays closed while its item is held or the answer waits
	assign AWREADY = !aw_held && !BVALID;
	assign WREADY  = !w_held && !BVALID;
	assign ARREADY = !ar_pend && !RVALID;

	wire do_write = aw_held && w_held && !BVALID;
	wire wr_bank  = (aw_addr < 12'(RSQ_BANK_TOP)) && (aw_addr[1:0] == 2'b00);
	wire wr_vecld = (aw_addr == RSQ_VECLD_ADDR);
	wire sw_we    = do_write && wr_bank && w_strb[0] && !init_busy;
	wire rd_bank  = (ar_addr < 12'(RSQ_BANK_TOP)) && (ar_addr[1:0] == 2'b00);
	wire rd_stat  = (ar_addr == RSQ_STATUS_ADDR);
	wire rd_vec   = (ar_addr == RSQ_VECTOR_ADDR);
	wire rd_vecld = (ar_addr == RSQ_VECLD_ADDR);
	wire rd_ok    = rd_bank || rd_stat || rd_vec || rd_vecld;
	wire wr_ok    = wr_bank || wr_vecld;

	//------------------------------------------------------------
	// register bank
	//------------------------------------------------------------

	// reset load has priority over software writes
	wire       mem_we    = (init_busy && !init_keep) || sw_we;
	wire [5:0] mem_waddr = init_busy ? init_idx : aw_addr[7:2];
	wire [7:0] mem_wdata = init_busy ? init_val : w_data[7:0];

	rsq_reg_mem u_mem (
		.clk_i   (SYS_CLK_I),
		.we_i    (mem_we),
		.waddr_i (mem_waddr),
		.wdata_i (mem_wdata),
		.raddr_i (ar_addr[7:2]),
		.rdata_o (mem_rdata)
	);

	//------------------------------------------------------------
	// write channels
	//------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (AWVALID && AWREADY) begin
			aw_held <= 1'b1;
			aw_addr <= AWADDR;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (WVALID && WREADY) begin
			w_held <= 1'b1;
			w_data <= WDATA;
			w_strb <= WSTRB;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	// response follows once address and data are both held
	wire [1:0] next_bresp = wr_ok ? RSQ_RESP_OKAY : RSQ_RESP_SLVERR;

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			BVALID <= 1'b0;
			BRESP  <= RSQ_RESP_OKAY;
		end else if (do_write) begin
			BVALID <= 1'b1;
			BRESP  <= next_bresp;
		end else if (BVALID && BREADY) begin
			BVALID <= 1'b0;
		end
	end

	// vector bytes survive a pin reset
	wire vec_lo_we = do_write && wr_vecld && w_strb[0];
	wire vec_hi_we = do_write && wr_vecld && w_strb[1];

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			vec_lo <= '0;
			vec_hi <= '0;
		end else begin
			if (vec_lo_we)
				vec_lo <= w_data[7:0];
			if (vec_hi_we)
				vec_hi <= w_data[15:8];
		end
	end

	//------------------------------------------------------------
	// read channel
	//------------------------------------------------------------
	wire        rd_fire   = ar_pend && !rd_wait && !RVALID;
	wire [3:0]  stat_bits = {MID_SPEED_O, START_VALID_O, init_busy, core_rst};
	wire [31:0] next_rdata = rd_bank  ? {24'h000000, mem_rdata} :
	                         rd_stat  ? {28'h0000000, stat_bits} :
	                         rd_vec   ? {16'h0000, start_addr} :
	                         rd_vecld ? {16'h0000, vec_hi, vec_lo} : 32'h00000000;
	wire [1:0]  next_rresp = rd_ok ? RSQ_RESP_OKAY : RSQ_RESP_SLVERR;

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			ar_pend <= 1'b0;
			ar_addr <= '0;
		end else if (ARVALID && ARREADY) begin
			ar_pend <= 1'b1;
			ar_addr <= ARADDR;
		end else if (RVALID && RREADY) begin
			ar_pend <= 1'b0;
		end
	end

	// bank data come out of a register one cycle after the index
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I)
			rd_wait <= 1'b0;
		else
			rd_wait <= ARVALID && ARREADY;
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			RVALID <= 1'b0;
			RDATA  <= '0;
			RRESP  <= RSQ_RESP_OKAY;
		end else if (rd_fire) begin
			RVALID <= 1'b1;
			RDATA  <= next_rdata;
			RRESP  <= next_rresp;
		end else if (RVALID && RREADY) begin
			RVALID <= 1'b0;
		end
	end
endmodule : rsq_top

/* File: verification/rsq_checker.sv */
// rsq_checker: port-level assertions for the reset sequencer
// assumes: bound into rsq_top; one clock domain, RESETN_I async active low
`timescale 1ns/100ps
module rsq_checker
	import rsq_pkg::*;
(
	input wire logic        SYS_CLK_I,      // main oscillator
	input wire logic        RESETN_I,       // async reset, active low
	input wire logic        RESET_PIN_N_I,  // reset pin, active low
	input wire logic        CORE_RESET_N_O, // internal reset, active low
	input wire logic        CLK_PHI_EN_O,   // phase enable pulse
	input wire logic        MID_SPEED_O,    // middle-speed mode
	input wire logic [15:0] START_ADDR_O,   // start address
	input wire logic        START_VALID_O,  // start address valid
	input wire logic        BVALID,         // write response valid
	input wire logic        BREADY,         // write response ready
	input wire logic        RVALID,         // read data valid
	input wire logic        RREADY,         // read data ready
	input wire logic [1:0]  RRESP           // read response
);
	logic [5:0] low_cnt;
	logic [5:0] last_run;

	default clocking dcb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RESETN_I);

	// length of the current and of the last low run on the pin
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			low_cnt  <= 6'h00;
			last_run <= 6'h00;
		end else if (RESET_PIN_N_I) begin
			low_cnt <= 6'h00;
			if (low_cnt != 6'h00)
				last_run <= low_cnt;
		end else if (low_cnt != 6'h3f) begin
			low_cnt <= low_cnt + 6'h01;
		end
	end

	short_pulse_a: assert property ($fell(CORE_RESET_N_O) |->
		(low_cnt >= 6'h10) || (last_run >= 6'h10)) else $error("reset taken on short pulse");
	hold_low_a: assert property (low_cnt >= 6'h18 |-> !CORE_RESET_N_O)
		else $error("core out of reset while pin held low");
	release_a: assert property ($rose(RESET_PIN_N_I) && low_cnt >= 6'h10
		|-> ##[1:100] CORE_RESET_N_O) else $error("core reset not released");
	run_flags_a: assert property ($rose(CORE_RESET_N_O) |->
		(MID_SPEED_O && START_VALID_O) ##[1:8] CLK_PHI_EN_O)
		else $error("run without mode or phase pulse");
	addr_stable_a: assert property (START_VALID_O && $past(START_VALID_O)
		|-> $stable(START_ADDR_O)) else $error("start address moved");
	phi_gap_a: assert property (CLK_PHI_EN_O |=> (!CLK_PHI_EN_O) [*7])
		else $error("phase pulses too close");
	phi_every_a: assert property (CLK_PHI_EN_O ##1 MID_SPEED_O [*8] |-> CLK_PHI_EN_O)
		else $error("phase pulse missing");
	b_once_a: assert property (BVALID && BREADY |=> !BVALID)
		else $error("write response repeated");
	r_once_a: assert property (RVALID && RREADY |=> !RVALID)
		else $error("read response repeated");

	cover property ($fell(CORE_RESET_N_O));
	cover property ($rose(CORE_RESET_N_O));
	cover property (RVALID && RRESP == RSQ_RESP_SLVERR);
endmodule : rsq_checker

bind rsq_top rsq_checker u_chk (.SYS_CLK_I, .RESETN_I, .RESET_PIN_N_I, .CORE_RESET_N_O,
	.CLK_PHI_EN_O, .MID_SPEED_O, .START_ADDR_O, .START_VALID_O, .BVALID, .BREADY,
	.RVALID, .RREADY, .RRESP);

/* File: verification/rsq_supervisor.sv */
// rsq_supervisor: behavioural reset supervisor and supply monitor on the reset pin
// assumes: pwr_ok_i low while the supply ramps; start_i is a one-cycle request
`timescale 1ns/100ps
module rsq_supervisor #(
	parameter int SETTLE_CYC = 8 // internal supply settling, in clocks
) (
	input  wire logic       clk_i,     // main oscillator
	input  wire logic       pwr_ok_i,  // supply good, low while ramping
	input  wire logic       start_i,   // request one reset pulse
	input  wire logic [5:0] low_cyc_i, // low time in clocks, less one
	output logic            pin_n_o    // reset pin, active low
);
	logic [6:0] cnt;

	always_ff @(posedge clk_i or negedge pwr_ok_i) begin
		if (!pwr_ok_i) begin
			pin_n_o <= 1'h0;
			cnt     <= 7'(SETTLE_CYC) + {1'h0, low_cyc_i};
		end else if (start_i) begin
			pin_n_o <= 1'h0;
			cnt     <= {1'h0, low_cyc_i};
		end else if (cnt != 7'h00) begin
			cnt <= cnt - 7'h01;
		end else begin
			pin_n_o <= 1'h1;
		end
	end
endmodule : rsq_supervisor

/* File: verification/tb_top.sv */
// tb_top: directed tests of the reset sequencer over axi4-lite and the reset pin
// assumes: rsq_top, rsq_supervisor and the bound checker are compiled alongside
`timescale 1ns/100ps
module tb_top;
	import rsq_pkg::*;
	logic        SYS_CLK_I = 1'h0;
	logic        RESETN_I  = 1'h0;
	logic        RESET_PIN_N_I, CORE_RESET_N_O, CLK_PHI_EN_O, MID_SPEED_O, START_VALID_O;
	logic [15:0] START_ADDR_O;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [1:0]  BRESP, RRESP, rsp;
	logic [31:0] RDATA, rd;
	logic        AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
	logic [11:0] AWADDR  = 12'h000, ARADDR = 12'h000;
	logic [31:0] WDATA   = 32'h0;
	logic [3:0]  WSTRB   = 4'h0;
	logic        sup_go  = 1'h0;
	logic [5:0]  sup_low = 6'h10;
	int          errors  = 0, n_tests = 0, cyc = 0;

	always #50 SYS_CLK_I = ~SYS_CLK_I;

	rsq_top uut (.SYS_CLK_I, .RESETN_I, .RESET_PIN_N_I, .CORE_RESET_N_O, .CLK_PHI_EN_O,
		.MID_SPEED_O, .START_ADDR_O, .START_VALID_O, .AWVALID, .AWREADY, .AWADDR, .WVALID,
		.WREADY, .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR,
		.RVALID, .RREADY, .RDATA, .RRESP);
	rsq_supervisor u_sup (.clk_i(SYS_CLK_I), .pwr_ok_i(RESETN_I), .start_i(sup_go),
		.low_cyc_i(sup_low), .pin_n_o(RESET_PIN_N_I));

	//----------------------------------------------------------------
	// bus and check tasks
	//----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw_t, w_t, b_t;
		b_t = 1'h0;
		AWADDR  <= a;
		WDATA   <= d;
		WSTRB   <= 4'hf;
		AWVALID <= 1'h1;
		WVALID  <= 1'h1;
		BREADY  <= 1'h1;
		while (!b_t) begin
			@(negedge SYS_CLK_I);
			aw_t = AWVALID && AWREADY;
			w_t  = WVALID && WREADY;
			b_t  = BVALID === 1'h1;
			r    = BRESP;
			@(posedge SYS_CLK_I);
			if (aw_t)
				AWVALID <= 1'h0;
			if (w_t)
				WVALID <= 1'h0;
		end
		BREADY <= 1'h0;
		@(posedge SYS_CLK_I);
	endtask : axi_wr

	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		bit a_t, r_t;
		r_t = 1'h0;
		ARADDR  <= a;
		ARVALID <= 1'h1;
		RREADY  <= 1'h1;
		while (!r_t) begin
			@(negedge SYS_CLK_I);
			a_t = ARVALID && ARREADY;
			r_t = RVALID === 1'h1;
			d   = RDATA;
			r   = RRESP;
			@(posedge SYS_CLK_I);
			if (a_t)
				ARVALID <= 1'h0;
		end
		RREADY <= 1'h0;
		@(posedge SYS_CLK_I);
	endtask : axi_rd

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		axi_rd(a, rd, rsp);
		check("read data", rd, e);
		check("read resp", {30'h0, rsp}, {30'h0, RSQ_RESP_OKAY});
	endtask : rd_chk

	task automatic wait_run();
		int n;
		n = 0;
		while (CORE_RESET_N_O !== 1'h1 && n < 300) begin
			@(negedge SYS_CLK_I);
			n++;
		end
		@(posedge SYS_CLK_I);
		check("core reset released", {31'h0, CORE_RESET_N_O}, 32'h1);
	endtask : wait_run

	task automatic pin_pulse(input logic [5:0] len);
		sup_low <= len;
		sup_go  <= 1'h1;
		@(posedge SYS_CLK_I);
		sup_go <= 1'h0;
	endtask : pin_pulse

	//----------------------------------------------------------------
	// scenarios
	//----------------------------------------------------------------
	task automatic t_power_on();
		logic [5:0] idx [12] = '{6'h0e, 6'h0f, 6'h19, 6'h1b, 6'h28, 6'h29, 6'h36, 6'h37,
			6'h3c, 6'h3d, 6'h3e, 6'h3f};
		logic [7:0] val [12] = '{8'h33, 8'h33, 8'h80, 8'he0, 8'hff, 8'hff, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h00, 8'h00};
		wait_run();
		check("start address", {16'h0, START_ADDR_O}, 32'h0);
		for (int i = 0; i < 14; i++)
			rd_chk({4'h0, 6'(i), 2'h0}, 32'h0);
		for (int i = 0; i < 12; i++)
			rd_chk({4'h0, idx[i], 2'h0}, {24'h0, val[i]});
		$display("t_power_on done");
	endtask : t_power_on

	task automatic t_vector();
		axi_wr(12'h108, 32'h5a3c, rsp);
		axi_wr(12'h004, 32'ha5, rsp);
		axi_wr(12'h038, 32'h12, rsp);
		rd_chk(12'h004, 32'ha5);
		pin_pulse(6'h0f);
		repeat (30) @(negedge SYS_CLK_I);
		check("core in reset", {31'h0, CORE_RESET_N_O}, 32'h0);
		check("mode in reset", {31'h0, MID_SPEED_O}, 32'h0);
		check("valid in reset", {31'h0, START_VALID_O}, 32'h0);
		wait_run();
		check("start address", {16'h0, START_ADDR_O}, 32'h5a3c);
		rd_chk(12'h104, 32'h5a3c);
		rd_chk(12'h004, 32'h0);
		rd_chk(12'h038, 32'h33);
		rd_chk(12'h100, 32'hc);
		$display("t_vector done");
	endtask : t_vector

	task automatic t_glitch();
		bit dropped;
		dropped = 1'h0;
		axi_wr(12'h004, 32'h5a, rsp);
		pin_pulse(6'h0e);
		repeat (40) begin
			@(negedge SYS_CLK_I);
			dropped |= CORE_RESET_N_O !== 1'h1;
		end
		@(posedge SYS_CLK_I);
		check("short pulse ignored", {31'h0, dropped}, 32'h0);
		rd_chk(12'h004, 32'h5a);
		$display("t_glitch done");
	endtask : t_glitch

	task automatic t_phi();
		int n;
		n = 0;
		repeat (80) begin
			@(negedge SYS_CLK_I);
			n += (CLK_PHI_EN_O === 1'h1);
		end
		@(posedge SYS_CLK_I);
		check("phase pulses", 32'(n), 32'd10);
		$display("t_phi done");
	endtask : t_phi

	task automatic t_unmapped();
		axi_rd(12'h200, rd, rsp);
		check("unmapped data", rd, 32'h0);
		check("unmapped read resp", {30'h0, rsp}, {30'h0, RSQ_RESP_SLVERR});
		axi_wr(12'h200, 32'h1, rsp);
		check("unmapped write resp", {30'h0, rsp}, {30'h0, RSQ_RESP_SLVERR});
		$display("t_unmapped done");
	endtask : t_unmapped

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out

	always @(posedge SYS_CLK_I) begin
		cyc++;
		if (cyc == 6000) begin
			errors++;
			close_out();
		end
	end

	initial begin
		repeat (12) @(posedge SYS_CLK_I);
		RESETN_I <= 1'h1;
		t_power_on();
		t_vector();
		t_glitch();
		t_phi();
		t_unmapped();
		close_out();
	end
endmodule : tb_top
